// File: common/char_cmd_pkg.sv
// constants, types and timing for the character display command unit
package char_cmd_pkg;
   // ----------------------------------------
   // clock and oscillator timing
   // ----------------------------------------
   localparam int unsigned CLK_KHZ = 250000;
   localparam int unsigned OSC_REF_KHZ = 250;
   localparam int unsigned OSC_DIV = CLK_KHZ / OSC_REF_KHZ;
   localparam longint unsigned NS_PER_MS_KHZ = 64'hF4240;
   localparam longint unsigned INIT_TIME_NS = 64'h989680;
   localparam longint unsigned LONG_TIME_NS = 64'h190640;
   localparam longint unsigned SHORT_TIME_NS = 64'h9C40;
   localparam int BUSY_W = 12;
   // all three times round down to whole oscillator ticks
   localparam logic [BUSY_W-1:0] INIT_TICKS =
      BUSY_W'((INIT_TIME_NS * OSC_REF_KHZ) / NS_PER_MS_KHZ);
   localparam logic [BUSY_W-1:0] LONG_TICKS =
      BUSY_W'((LONG_TIME_NS * OSC_REF_KHZ) / NS_PER_MS_KHZ);
   localparam logic [BUSY_W-1:0] SHORT_TICKS =
      BUSY_W'((SHORT_TIME_NS * OSC_REF_KHZ) / NS_PER_MS_KHZ);
   // ----------------------------------------
   // bus and field layout
   // ----------------------------------------
   localparam int DATA_W = 8;
   localparam int NIB_W = 4;
   localparam int PTR_W = 7;
   localparam int FUNC_WIDTH_BIT = 4;
   localparam int FUNC_LINES_BIT = 3;
   localparam int FUNC_FONT_BIT = 2;
   localparam int DISP_ON_BIT = 2;
   localparam int DISP_CURSOR_BIT = 1;
   localparam int DISP_BLINK_BIT = 0;
   localparam int ENTRY_DIR_BIT = 1;
   localparam int ENTRY_SHIFT_BIT = 0;
   localparam int GLYPH_ADDR_W = 6;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0, CMD_CLEAR = 4'h1, CMD_HOME = 4'h2, CMD_ENTRY = 4'h3,
      CMD_DISPLAY = 4'h4, CMD_SHIFT = 4'h5, CMD_FUNC = 4'h6,
      CMD_GLYPH_ADDR = 4'h7, CMD_TEXT_ADDR = 4'h8
   } cmd_e;
   typedef enum logic [1:0] {
      ST_INIT = 2'b00, ST_IDLE = 2'b01, ST_EXEC = 2'b10
   } state_e;
   typedef struct packed {
      logic busWidthSelect;
      logic twoLines;
      logic tallFont;
      logic displayOn;
      logic cursorOn;
      logic blinkOn;
      logic stepUp;
      logic shiftOnWrite;
   } cfg_s;
   typedef struct packed {
      logic regSelect;
      logic readNotWrite;
      logic strobe;
      logic [DATA_W-1:0] data;
   } pins_s;
   localparam cfg_s INIT_CFG = '{busWidthSelect: 1'h1, twoLines: 1'h0,
      tallFont: 1'h0, displayOn: 1'h0, cursorOn: 1'h0, blinkOn: 1'h0,
      stepUp: 1'h1, shiftOnWrite: 1'h0};
endpackage

// File: hdl/character_display_command_unit.sv
// host command front end of a character display controller
// Summary of operation
// - power-on runs clear, function, display, entry setup
// - busy stays high through power-on setup
// - power-on busy lasts ten milliseconds
// - setup leaves 8-bit, one line, all off, increment
// - two host registers: command and transfer holding
// - access is select, direction and eight data lines
// - data transfer steps pointer up or down
// - shift-on-write shifts display with data write
// - busy from acceptance until execution ends
// - while busy only busy/pointer read executes
// - clear command blanks memory, zeroes pointer
// - home command zeroes pointer and shift
// - entry command stores direction and shift enable
// - direction and shift apply on reads too
// - 4-bit mode moves high nibble then low
// - busy/pointer read returns at once
// - function command stores width, lines, font
// - display command stores display, cursor, blink
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module character_display_command_unit #(
   parameter int unsigned OSC_DIV = char_cmd_pkg::OSC_DIV,
   parameter logic [char_cmd_pkg::BUSY_W-1:0] INIT_TICKS =
      char_cmd_pkg::INIT_TICKS
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic registerSelectLine,
   input wire logic readWriteLine,
   input wire logic enableStrobeLine,
   input wire logic [char_cmd_pkg::DATA_W-1:0] parallelBusLinesIn,
   output logic [char_cmd_pkg::DATA_W-1:0] parallelBusLinesOut,
   output logic parallelBusLinesOe_n,
   input wire logic [char_cmd_pkg::DATA_W-1:0] textMemoryReadData,
   output logic textMemoryWrite,
   output logic [char_cmd_pkg::PTR_W-1:0] textMemoryWriteAddr,
   output logic [char_cmd_pkg::DATA_W-1:0] textMemoryWriteData,
   output logic textMemoryClear,
   output logic [char_cmd_pkg::PTR_W-1:0] positionPointer,
   output logic [char_cmd_pkg::PTR_W-1:0] displayShift,
   output char_cmd_pkg::cfg_s modeConfig,
   output logic internalBusyIndicator
);
   import char_cmd_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic cmd_e decodeCmd(input logic [DATA_W-1:0] b);
      cmd_e c;
      c = CMD_NONE;
      if (b[7]) c = CMD_TEXT_ADDR;
      else if (b[6]) c = CMD_GLYPH_ADDR;
      else if (b[5]) c = CMD_FUNC;
      else if (b[4]) c = CMD_SHIFT;
      else if (b[3]) c = CMD_DISPLAY;
      else if (b[2]) c = CMD_ENTRY;
      else if (b[1]) c = CMD_HOME;
      else if (b[0]) c = CMD_CLEAR;
      return c;
   endfunction

   function automatic logic [PTR_W-1:0] stepPtr(
      input logic [PTR_W-1:0] p, input logic up);
      return up ? p + 1'h1 : p - 1'h1;
   endfunction

   // ----------------------------------------
   // pin sampling
   // ----------------------------------------
   pins_s rawPins;
   pins_s pins;
   logic tick;
   assign rawPins = '{regSelect: registerSelectLine,
      readNotWrite: readWriteLine, strobe: enableStrobeLine,
      data: parallelBusLinesIn};

   // data lines cross with the strobe; the host holds them steady
   // around the strobe edge, so a two-cycle lag is harmless
   pin_sync #(.W($bits(pins_s))) pinSyncU (
      .clk(clk),
      .arst_n(arst_n),
      .din(rawPins),
      .dout(pins)
   );

   osc_tick_div #(.DIV(OSC_DIV)) oscU (
      .clk(clk),
      .arst_n(arst_n),
      .tick(tick)
   );

   // ----------------------------------------
   // access decode
   // ----------------------------------------
   state_e state_q;
   cfg_s cfg_q;
   logic strobePrev_q;
   logic phaseLow_q;
   logic [NIB_W-1:0] hiNibble_q;
   logic [DATA_W-1:0] readByte_q;
   logic [DATA_W-1:0] commandHoldingRegister_q;
   logic [DATA_W-1:0] transferHoldingRegister_q;
   logic [PTR_W-1:0] pointer_q;
   logic [PTR_W-1:0] shift_q;
   logic [BUSY_W-1:0] busyTicks_q;
   logic [1:0] initStep_q;
   logic initRun_q;
   logic strobeRise, strobeFall, idle, byteDone;
   logic isBusyRead, isDataRead, isCmdWrite, isDataWrite;
   logic countedFall, accept, cmdAccept, dwAccept, drAccept;
   logic [DATA_W-1:0] fullByte, readValue;
   cmd_e cmd;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) strobePrev_q <= 1'h0;
      else strobePrev_q <= pins.strobe;
   end

   assign strobeRise = pins.strobe && !strobePrev_q;
   assign strobeFall = !pins.strobe && strobePrev_q;
   assign idle = (state_q == ST_IDLE);
   assign internalBusyIndicator = !idle;
   assign isBusyRead = !pins.regSelect && pins.readNotWrite;
   assign isDataRead = pins.regSelect && pins.readNotWrite;
   assign isCmdWrite = !pins.regSelect && !pins.readNotWrite;
   assign isDataWrite = pins.regSelect && !pins.readNotWrite;
   assign byteDone = cfg_q.busWidthSelect || phaseLow_q;
   assign fullByte = cfg_q.busWidthSelect ? pins.data :
      {hiNibble_q, pins.data[DATA_W-1 -: NIB_W]};
   // ignored strobes leave no trace at all, not even a nibble step
   assign countedFall = strobeFall && (idle || isBusyRead);
   assign accept = strobeFall && byteDone && idle && !isBusyRead;
   assign cmd = decodeCmd(fullByte);
   assign cmdAccept = accept && isCmdWrite;
   assign dwAccept = accept && isDataWrite;
   assign drAccept = accept && isDataRead;
   assign readValue = isBusyRead ? {internalBusyIndicator, pointer_q} :
      textMemoryReadData;

   // ----------------------------------------
   // nibble pairing
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phaseLow_q <= 1'h0;
         hiNibble_q <= '0;
      end else if (cfg_q.busWidthSelect) begin
         phaseLow_q <= 1'h0;
      end else if (countedFall) begin
         if (!phaseLow_q) hiNibble_q <= pins.data[DATA_W-1 -: NIB_W];
         phaseLow_q <= !phaseLow_q;
      end
   end

   // ----------------------------------------
   // read drive
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         parallelBusLinesOut <= '0;
         parallelBusLinesOe_n <= 1'h1;
         readByte_q <= '0;
      end else if (strobeRise && pins.readNotWrite &&
         (idle || isBusyRead)) begin
         parallelBusLinesOe_n <= 1'h0;
         if (cfg_q.busWidthSelect) begin
            parallelBusLinesOut <= readValue;
         end else if (!phaseLow_q) begin
            readByte_q <= readValue;
            parallelBusLinesOut <= {readValue[DATA_W-1 -: NIB_W], 4'h0};
         end else begin
            parallelBusLinesOut <= {readByte_q[NIB_W-1:0], 4'h0};
         end
      end else if (strobeFall) begin
         parallelBusLinesOe_n <= 1'h1;
      end
   end

   // ----------------------------------------
   // holding registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) commandHoldingRegister_q <= '0;
      else if (cmdAccept) commandHoldingRegister_q <= fullByte;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) transferHoldingRegister_q <= '0;
      else if (dwAccept) transferHoldingRegister_q <= fullByte;
      else if (strobeRise && isDataRead && idle)
         transferHoldingRegister_q <= textMemoryReadData;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         textMemoryWrite <= 1'h0;
         textMemoryWriteAddr <= '0;
      end else begin
         textMemoryWrite <= dwAccept;
         if (dwAccept) textMemoryWriteAddr <= pointer_q;
      end
   end
   assign textMemoryWriteData = transferHoldingRegister_q;

   // ----------------------------------------
   // power-on setup sequence
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         initStep_q <= 2'h0;
         initRun_q <= 1'h1;
      end else if (initRun_q) begin
         initStep_q <= initStep_q + 2'h1;
         if (initStep_q == 2'h3) initRun_q <= 1'h0;
      end
   end

   // ----------------------------------------
   // mode settings
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q <= INIT_CFG;
      end else if (initRun_q) begin
         unique case (initStep_q)
            2'h0: ;
            2'h1: begin
               cfg_q.busWidthSelect <= INIT_CFG.busWidthSelect;
               cfg_q.twoLines <= INIT_CFG.twoLines;
               cfg_q.tallFont <= INIT_CFG.tallFont;
            end
            2'h2: begin
               cfg_q.displayOn <= INIT_CFG.displayOn;
               cfg_q.cursorOn <= INIT_CFG.cursorOn;
               cfg_q.blinkOn <= INIT_CFG.blinkOn;
            end
            2'h3: begin
               cfg_q.stepUp <= INIT_CFG.stepUp;
               cfg_q.shiftOnWrite <= INIT_CFG.shiftOnWrite;
            end
         endcase
      end else if (cmdAccept) begin
         if (cmd == CMD_FUNC) begin
            cfg_q.busWidthSelect <= fullByte[FUNC_WIDTH_BIT];
            cfg_q.twoLines <= fullByte[FUNC_LINES_BIT];
            cfg_q.tallFont <= fullByte[FUNC_FONT_BIT];
         end
         if (cmd == CMD_DISPLAY) begin
            cfg_q.displayOn <= fullByte[DISP_ON_BIT];
            cfg_q.cursorOn <= fullByte[DISP_CURSOR_BIT];
            cfg_q.blinkOn <= fullByte[DISP_BLINK_BIT];
         end
         if (cmd == CMD_ENTRY) begin
            cfg_q.stepUp <= fullByte[ENTRY_DIR_BIT];
            cfg_q.shiftOnWrite <= fullByte[ENTRY_SHIFT_BIT];
         end
      end
   end
   assign modeConfig = cfg_q;

   // ----------------------------------------
   // pointer, shift and clear
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pointer_q <= '0;
      end else if (initRun_q && initStep_q == 2'h0) begin
         pointer_q <= '0;
      end else if (cmdAccept && (cmd == CMD_CLEAR || cmd == CMD_HOME)) begin
         pointer_q <= '0;
      end else if (cmdAccept && cmd == CMD_TEXT_ADDR) begin
         pointer_q <= fullByte[PTR_W-1:0];
      end else if (cmdAccept && cmd == CMD_GLYPH_ADDR) begin
         pointer_q <= {1'h0, fullByte[GLYPH_ADDR_W-1:0]};
      end else if (dwAccept || drAccept) begin
         pointer_q <= stepPtr(pointer_q, cfg_q.stepUp);
      end
   end
   assign positionPointer = pointer_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_q <= '0;
      end else if (initRun_q && initStep_q == 2'h0) begin
         shift_q <= '0;
      end else if (cmdAccept && (cmd == CMD_CLEAR || cmd == CMD_HOME)) begin
         shift_q <= '0;
      end else if ((dwAccept || drAccept) && cfg_q.shiftOnWrite) begin
         shift_q <= stepPtr(shift_q, cfg_q.stepUp);
      end
   end
   assign displayShift = shift_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) textMemoryClear <= 1'h0;
      else textMemoryClear <= (initRun_q && initStep_q == 2'h0) ||
         (cmdAccept && cmd == CMD_CLEAR);
   end

   // ----------------------------------------
   // busy timing
   // ----------------------------------------
   // times are in oscillator ticks, so they track the divider setting
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busyTicks_q <= INIT_TICKS;
      end else if (accept) begin
         busyTicks_q <= (isCmdWrite && (cmd == CMD_CLEAR || cmd == CMD_HOME))
            ? LONG_TICKS : SHORT_TICKS;
      end else if (tick && busyTicks_q != '0) begin
         busyTicks_q <= busyTicks_q - 1'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_INIT;
      end else begin
         unique case (state_q)
            ST_INIT: if (!initRun_q && busyTicks_q == '0) state_q <= ST_IDLE;
            ST_IDLE: if (accept) state_q <= ST_EXEC;
            ST_EXEC: if (busyTicks_q == '0) state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   logic [BUSY_W-1:0] initTickCnt_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) initTickCnt_q <= '0;
      else if (state_q == ST_INIT && tick)
         initTickCnt_q <= initTickCnt_q + 1'h1;
   end

   sequence setupSteps_s;
      initStep_q == 2'h1 ##1 initStep_q == 2'h2 ##1 initStep_q == 2'h3;
   endsequence

   setup_order_a: assert property (
      initRun_q && initStep_q == 2'h0 |=> textMemoryClear ##0 setupSteps_s)
      else $error("power-on setup steps out of order");
   setup_busy_a: assert property (
      $fell(internalBusyIndicator) && $past(state_q) == ST_INIT |->
      !$past(initRun_q))
      else $error("busy dropped before setup finished");
   setup_length_a: assert property (
      $fell(internalBusyIndicator) && $past(state_q) == ST_INIT |->
      initTickCnt_q >= INIT_TICKS)
      else $error("power-on busy too short");
   setup_state_a: assert property (
      initRun_q && initStep_q == 2'h3 |=> modeConfig == INIT_CFG)
      else $error("wrong state after power-on setup");
   pointer_step_a: assert property (
      dwAccept || drAccept |=> positionPointer ==
      stepPtr($past(positionPointer), $past(cfg_q.stepUp)))
      else $error("pointer not stepped after transfer");
   shift_write_a: assert property (
      dwAccept && cfg_q.shiftOnWrite |=> displayShift != $past(displayShift))
      else $error("display not shifted on write");
   busy_accept_a: assert property (
      accept |=> internalBusyIndicator [*2])
      else $error("busy not held after acceptance");
   busy_ignore_a: assert property (
      strobeFall && state_q == ST_EXEC && !isBusyRead |=>
      $stable(modeConfig) && $stable(positionPointer) && !textMemoryWrite)
      else $error("access acted on while busy");
   clear_cmd_a: assert property (
      cmdAccept && cmd == CMD_CLEAR |=> positionPointer == '0 &&
      textMemoryClear && busyTicks_q == LONG_TICKS)
      else $error("clear command misbehaved");
   home_cmd_a: assert property (
      cmdAccept && cmd == CMD_HOME |=> positionPointer == '0 &&
      displayShift == '0 && !textMemoryClear)
      else $error("home command misbehaved");
   entry_cmd_a: assert property (
      cmdAccept && cmd == CMD_ENTRY |=> busyTicks_q == SHORT_TICKS &&
      modeConfig.stepUp == $past(fullByte[ENTRY_DIR_BIT]))
      else $error("entry mode not stored");
   busy_read_a: assert property (
      strobeRise && isBusyRead && cfg_q.busWidthSelect |=>
      !parallelBusLinesOe_n &&
      parallelBusLinesOut == {$past(internalBusyIndicator), $past(pointer_q)})
      else $error("busy/pointer read wrong");
endmodule
`default_nettype wire

// File: hdl/osc_tick_div.sv
// divider that stands in for the internal oscillator as a tick pulse
`timescale 1ns/1ns
`default_nettype none
module osc_tick_div #(
   parameter int unsigned DIV = 1000
) (
   input wire logic clk,
   input wire logic arst_n,
   output logic tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   logic [CW-1:0] cnt_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
         tick <= 1'h0;
      end else begin
         tick <= (cnt_q == LAST);
         cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'h1;
      end
   end
endmodule
`default_nettype wire

// File: hdl/pin_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         dout <= '0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule
`default_nettype wire

// File: verification/character_display_command_unit_tb.sv
// self-checking bench for the character display command unit
`timescale 1ns/1ns
`default_nettype none
module character_display_command_unit_tb;
   import char_cmd_pkg::*;
   // small divider and setup count keep the run short
   localparam int DIV = 2;
   localparam int INITN = 6;
   localparam int LONGN = int'(LONG_TICKS);
   logic clk, arst_n, rs, rw, stb, oe_n, memWr, memClr, busy;
   logic [DATA_W-1:0] busIn, busOut, memRd, wrData, q;
   logic [PTR_W-1:0] wrAddr, ptr, shift, p, s;
   cfg_s cfg;
   logic [DATA_W-1:0] mem [128];
   logic [DATA_W-1:0] ent [4] = '{8'h06, 8'h07, 8'h04, 8'h05};
   logic [DATA_W-1:0] setupCmd [4] = '{8'h30, 8'h08, 8'h01, 8'h06};
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   int clears = 0;
   int writes = 0;
   int n, w;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5A;
   end
   // ----------------------------------------
   // text memory stand-in and timeout
   // ----------------------------------------
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (memWr === 1'b1) begin
         mem[wrAddr] <= wrData;
         writes <= writes + 1;
      end
      if (memClr === 1'b1) begin
         clears <= clears + 1;
         for (int i = 0; i < 128; i++) mem[i] <= 8'h20;
      end
      if (cycles == 12000) begin
         err_count++;
         give_verdict();
      end
   end
   assign memRd = mem[ptr];
   host_bus_model host (.clk(clk), .rs(rs), .rw(rw), .stb(stb),
      .devOut(busOut), .devOe_n(oe_n), .busIn(busIn));
   character_display_command_unit #(.OSC_DIV(DIV), .INIT_TICKS(12'h006))
   uut (.clk(clk), .arst_n(arst_n), .registerSelectLine(rs),
      .readWriteLine(rw), .enableStrobeLine(stb),
      .parallelBusLinesIn(busIn), .parallelBusLinesOut(busOut),
      .parallelBusLinesOe_n(oe_n), .textMemoryReadData(memRd),
      .textMemoryWrite(memWr), .textMemoryWriteAddr(wrAddr),
      .textMemoryWriteData(wrData), .textMemoryClear(memClr),
      .positionPointer(ptr), .displayShift(shift), .modeConfig(cfg),
      .internalBusyIndicator(busy));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task waitIdle();
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) chk("idle wait", 8'h00, 8'h01);
   endtask
   task op(input logic rsV, input logic rwV, input logic [7:0] d);
      host.access(rsV, rwV, d, q);
      waitIdle();
   endtask
   task give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      arst_n = 1'b0;
      repeat (3) @(posedge clk);
      chk("busy in reset", 8'h01, busy);
      arst_n <= 1'b1;
      waitIdle();
      chk("setup window", 8'h01, n >= (INITN-1)*DIV && n <= INITN*DIV+8);
      chk("setup clear", 8'h01, 8'(clears));
      chk("setup config", INIT_CFG, cfg);
      $display("test power-on done");
      op(1'b1, 1'b0, 8'h41);
      chk("text 0", 8'h41, mem[0]);
      chk("pointer up", 8'h01, ptr);
      host.access(1'b0, 1'b0, 8'h01, q);
      w = writes;
      host.access(1'b1, 1'b0, 8'h42, q);
      host.access(1'b0, 1'b1, 8'h00, q);
      chk("busy read", 8'h80, q);
      waitIdle();
      chk("clear time", 8'h01,
         n >= (LONGN-1)*DIV-60 && n <= LONGN*DIV);
      chk("refused", 8'h01, writes == w && ptr == 0);
      chk("cleared", 8'h20, mem[0]);
      $display("test clear and refusal done");
      for (int i = 0; i < 4; i++) begin
         op(1'b0, 1'b0, ent[i]);
         chk("entry", {6'h00, ent[i][1:0]},
            {cfg.stepUp, cfg.shiftOnWrite});
         p = ptr;
         s = shift;
         op(1'b1, 1'b0, 8'h30);
         chk("step", ent[i][1] ? p + 7'h01 : p - 7'h01, ptr);
         chk("shift", {7'h00, ent[i][0]}, shift !== s);
      end
      $display("test entry modes done");
      op(1'b0, 1'b0, 8'h06);
      op(1'b0, 1'b0, 8'h82);
      op(1'b1, 1'b1, 8'h00);
      chk("read data", 8'h30, q);
      chk("read step", 8'h03, ptr);
      op(1'b0, 1'b0, 8'h0D);
      chk("display", 8'h05, {cfg.displayOn, cfg.cursorOn, cfg.blinkOn});
      op(1'b0, 1'b0, 8'h3F);
      chk("function", 8'h07,
         {cfg.busWidthSelect, cfg.twoLines, cfg.tallFont});
      op(1'b0, 1'b0, 8'h45);
      chk("glyph address", 8'h05, ptr);
      op(1'b0, 1'b0, 8'h1C);
      chk("shift no step", 8'h05, ptr);
      op(1'b0, 1'b0, 8'h03);
      chk("home time", 8'h01,
         n >= (LONGN-1)*DIV-20 && n <= LONGN*DIV);
      chk("home", 8'h00, {ptr | shift});
      $display("test commands done");
      // fixed gaps instead of polling, each beyond the longest busy time
      for (int i = 0; i < 4; i++) begin
         host.access(1'b0, 1'b0, setupCmd[i], q);
         repeat ((LONGN+1)*DIV) @(posedge clk);
      end
      chk("gap idle", 8'h00, busy);
      chk("host setup", INIT_CFG, cfg);
      chk("host clear", 8'h03, 8'(clears));
      $display("test host setup done");
      op(1'b0, 1'b0, 8'h2C);
      chk("narrow", 8'h00, cfg.busWidthSelect);
      host.access(1'b1, 1'b0, 8'hA0, q);
      op(1'b1, 1'b0, 8'h50);
      chk("nibble write", 8'hA5, mem[0]);
      host.access(1'b0, 1'b1, 8'h00, q);
      chk("nibble high", 8'h00, q);
      host.access(1'b0, 1'b1, 8'h00, q);
      chk("nibble low", 8'h10, q);
      $display("test narrow bus done");
      give_verdict();
   end
endmodule
`default_nettype wire

// File: verification/host_bus_model.sv
// host processor model that drives the parallel pin bus
`timescale 1ns/1ns
`default_nettype none
module host_bus_model #(
   parameter int HIGH_CYC = 6
) (
   input wire logic clk,
   output logic rs,
   output logic rw,
   output logic stb,
   input wire logic [char_cmd_pkg::DATA_W-1:0] devOut,
   input wire logic devOe_n,
   output wire logic [char_cmd_pkg::DATA_W-1:0] busIn
);
   import char_cmd_pkg::*;
   logic drive;
   logic [DATA_W-1:0] drv;
   logic [DATA_W-1:0] last;
   initial begin
      rs = 1'b0;
      rw = 1'b0;
      stb = 1'b0;
      drive = 1'b0;
      drv = 8'h00;
      last = 8'h00;
   end
   // released bus has no pull, so it toggles rather than holding stale data
   assign busIn = !devOe_n ? devOut : (drive ? drv : ~last);
   always @(posedge clk) begin
      last <= busIn;
   end
   // ----------------------------------------
   // one access: select, direction, eight lines
   // ----------------------------------------
   task automatic access(input logic rsV, input logic rwV,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
      @(posedge clk);
      rs <= rsV;
      rw <= rwV;
      drv <= d;
      drive <= !rwV;
      @(posedge clk);
      stb <= 1'b1;
      repeat (HIGH_CYC) @(posedge clk);
      q = busIn;
      stb <= 1'b0;
      // hold select and data past the synchroniser delay
      repeat (5) @(posedge clk);
      drive <= 1'b0;
   endtask
endmodule
`default_nettype wire
